// *** smf_mode_ctrl.sv ***
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module smf_mode_ctrl
  import smf_pkg::*;
#(
  parameter int unsigned BAUD_DIV = 16,
  parameter int unsigned TX_DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cts_n_pin,
  output logic rts_n_pin,
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic ir_pin_out,
  output logic rx_line_out,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_error,
  input wire logic framing_error_event,
  input wire logic noise_error_event,
  input wire logic overrun_error_event,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic irq
);

  localparam int unsigned DIV_W = (BAUD_DIV > 1) ? $clog2(BAUD_DIV) : 1;

  if (BAUD_DIV < 1) begin : g_bad_div
    $error("smf_mode_ctrl baud divider must be at least 1");
  end

  function automatic logic [31:0] writable_mask(input logic port_on);
    writable_mask = port_on ? SMF_FREE_MASK : (SMF_FREE_MASK | SMF_LOCKED_MASK);
  endfunction

  // ****
  // bus slave
  // ****
  logic dp_valid_reg;
  logic dp_write_reg;
  logic dp_word_reg;
  logic [SMF_ADDR_BITS-1:0] dp_addr_reg;
  logic rd_done_reg;
  logic take;
  logic wr_stall;
  logic wr_fire;
  logic rd_capture;

  logic [31:0] ctrl_one_reg;
  logic [31:0] serial_control_three_reg;
  logic [3:0] flag_reg;
  logic rx_full_reg;
  logic [7:0] rx_data_reg;
  logic port_on;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic buf_push;
  logic cts_level_reg;
  smf_tx_state_type tx_state_reg;

  assign port_on = ctrl_one_reg[SMF_PORT_ENABLE_BIT];
  assign take = hsel & hready & htrans[1];
  // data writes stall the bus while the buffer is full
  assign wr_stall = dp_valid_reg & dp_write_reg & (dp_addr_reg == SMF_DATA_OFFSET) & ~buf_in_ready;
  assign wr_fire = dp_valid_reg & dp_write_reg & dp_word_reg & ~wr_stall;
  assign rd_capture = dp_valid_reg & ~dp_write_reg & ~rd_done_reg;
  assign hreadyout = ~(wr_stall | rd_capture);
  assign hresp = 1'b0;
  assign buf_push = wr_fire & (dp_addr_reg == SMF_DATA_OFFSET);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_word_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else if (hready) begin
      dp_valid_reg <= take;
      dp_write_reg <= hwrite;
      dp_word_reg <= (hsize == 3'h2);
      dp_addr_reg <= haddr[SMF_ADDR_BITS-1:0];
    end
  end

  // reads take one wait state so read data always comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_reg <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      if (rd_capture) begin
        rd_done_reg <= 1'b1;
        unique case (dp_addr_reg)
          SMF_CTRL_ONE_OFFSET: hrdata <= ctrl_one_reg;
          SMF_STATUS_OFFSET: hrdata <= {24'h00_0000, (tx_state_reg != SMF_TX_IDLE), rx_full_reg,
                                        buf_in_ready, cts_level_reg, flag_reg};
          SMF_CTRL_THREE_OFFSET: hrdata <= serial_control_three_reg;
          SMF_DATA_OFFSET: hrdata <= {24'h00_0000, rx_data_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end else if (hready) begin
        rd_done_reg <= 1'b0;
      end
    end
  end

  // ****
  // control registers
  // ****
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_reg <= SMF_CTRL_ONE_RESET;
    end else if (wr_fire && dp_addr_reg == SMF_CTRL_ONE_OFFSET) begin
      ctrl_one_reg <= {31'h0000_0000, hwdata[SMF_PORT_ENABLE_BIT]};
    end
  end

  // lock is judged on the port state before this write lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_control_three_reg <= SMF_CTRL_THREE_RESET;
    end else if (wr_fire && dp_addr_reg == SMF_CTRL_THREE_OFFSET) begin
      serial_control_three_reg <= (serial_control_three_reg & ~writable_mask(port_on))
                                  | (hwdata & writable_mask(port_on) & SMF_CTRL_THREE_MASK);
    end
  end

  logic error_irq_en;
  logic ir_en;
  logic ir_low_power;
  logic half_duplex;
  logic sc_nack_en;
  logic sc_en;
  logic rx_dma_en;
  logic tx_dma_en;
  logic rts_en;
  logic cts_en;
  logic cts_irq_en;

  assign error_irq_en = serial_control_three_reg[SMF_ERROR_IRQ_ENABLE_BIT];
  assign ir_en = serial_control_three_reg[SMF_INFRARED_MODE_ENABLE_BIT];
  assign ir_low_power = serial_control_three_reg[SMF_INFRARED_LOW_POWER_ENABLE_BIT];
  assign half_duplex = serial_control_three_reg[SMF_HALF_DUPLEX_ENABLE_BIT];
  assign sc_nack_en = serial_control_three_reg[SMF_SMARTCARD_NACK_ENABLE_BIT];
  assign sc_en = serial_control_three_reg[SMF_SMARTCARD_MODE_ENABLE_BIT];
  assign rx_dma_en = serial_control_three_reg[SMF_RX_DMA_REQUEST_ENABLE_BIT];
  assign tx_dma_en = serial_control_three_reg[SMF_TX_DMA_REQUEST_ENABLE_BIT];
  assign rts_en = serial_control_three_reg[SMF_REQUEST_TO_SEND_ENABLE_BIT];
  assign cts_en = serial_control_three_reg[SMF_CLEAR_TO_SEND_ENABLE_BIT];
  assign cts_irq_en = serial_control_three_reg[SMF_CTS_CHANGE_IRQ_ENABLE_BIT];

  // ****
  // pin synchronisers
  // ****
  logic [2:0] cts_sync_reg;
  logic [2:0] rx_sync_reg;
  logic [2:0] txin_sync_reg;
  logic rx_pin_level_reg;
  logic tx_pin_level_reg;
  logic cts_change;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_sync_reg <= 3'h7;
      rx_sync_reg <= 3'h7;
      txin_sync_reg <= 3'h7;
    end else begin
      cts_sync_reg <= {cts_sync_reg[1:0], cts_n_pin};
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
      txin_sync_reg <= {txin_sync_reg[1:0], tx_pin_in};
    end
  end

  // a level counts once stages two and three agree
  assign cts_change = (cts_sync_reg[1] == cts_sync_reg[2]) & (cts_sync_reg[2] != cts_level_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_level_reg <= 1'b1;
      rx_pin_level_reg <= 1'b1;
      tx_pin_level_reg <= 1'b1;
    end else begin
      if (cts_sync_reg[1] == cts_sync_reg[2]) begin
        cts_level_reg <= cts_sync_reg[2];
      end
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_pin_level_reg <= rx_sync_reg[2];
      end
      if (txin_sync_reg[1] == txin_sync_reg[2]) begin
        tx_pin_level_reg <= txin_sync_reg[2];
      end
    end
  end

  // ****
  // receive holding and flags
  // ****
  logic rx_pop;
  logic rx_nack_event;
  logic rx_overrun;
  logic [3:0] flag_set;
  logic [3:0] flag_clear;

  assign rx_pop = rd_capture & (dp_addr_reg == SMF_DATA_OFFSET);
  assign rx_nack_event = rx_char_valid & rx_parity_error & sc_en & sc_nack_en;
  assign rx_overrun = rx_char_valid & rx_full_reg & ~rx_pop;
  assign flag_set = {cts_change & cts_en, noise_error_event, overrun_error_event | rx_overrun,
                     framing_error_event};
  assign flag_clear = (wr_fire && dp_addr_reg == SMF_STATUS_OFFSET) ? hwdata[3:0] : 4'h0;

  // a rejected smartcard character is dropped, the card repeats it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (rx_char_valid && !rx_nack_event && (!rx_full_reg || rx_pop)) begin
      rx_full_reg <= 1'b1;
      rx_data_reg <= rx_char_data;
    end else if (rx_pop) begin
      rx_full_reg <= 1'b0;
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 4'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clear) | flag_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (error_irq_en & (|flag_reg[2:0]))
             | (cts_irq_en & flag_reg[SMF_CTS_CHANGE_FLAG_BIT]);
    end
  end

  // rts held high (stop) only while the holding register is occupied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n_pin <= 1'b0;
    end else begin
      rts_n_pin <= rts_en & rx_full_reg;
    end
  end

  assign rx_dma_req = rx_dma_en & rx_full_reg;
  assign tx_dma_req = tx_dma_en & buf_in_ready;

  // ****
  // transmit buffer
  // ****
  smf_tx_buffer #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) u_tx_buffer (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(hwdata[7:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ****
  // transmitter
  // ****
  logic [DIV_W-1:0] div_cnt_reg;
  logic [3:0] tick_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [9:0] shift_reg;
  logic nack_pending_reg;
  logic tick;
  logic cts_ok;
  logic tx_start;
  logic nack_start;
  logic bit_end;
  logic line_level;
  logic ir_pulse;

  assign tick = (div_cnt_reg == DIV_W'(BAUD_DIV - 1));
  assign bit_end = tick & (tick_cnt_reg == SMF_LAST_TICK);
  assign cts_ok = ~cts_en | ~cts_level_reg;
  assign nack_start = (tx_state_reg == SMF_TX_IDLE) & nack_pending_reg;
  // a held character simply waits in the buffer for cts
  assign tx_start = (tx_state_reg == SMF_TX_IDLE) & ~nack_pending_reg & port_on & buf_out_valid & cts_ok;
  assign buf_out_ready = tx_start;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nack_pending_reg <= 1'b0;
    end else if (rx_nack_event) begin
      nack_pending_reg <= 1'b1;
    end else if (nack_start) begin
      nack_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= '0;
      tick_cnt_reg <= 4'h0;
    end else if (tx_state_reg == SMF_TX_IDLE) begin
      div_cnt_reg <= '0;
      tick_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= tick ? '0 : div_cnt_reg + 1'b1;
      if (tick) begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
    end
  end

  // once started a frame runs to its stop bit whatever cts does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= SMF_TX_IDLE;
      shift_reg <= 10'h3FF;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (tx_state_reg)
        SMF_TX_IDLE: begin
          bit_cnt_reg <= 4'h0;
          if (nack_start) begin
            tx_state_reg <= SMF_TX_NACK;
          end else if (tx_start) begin
            shift_reg <= {1'b1, buf_out_data, 1'b0};
            tx_state_reg <= SMF_TX_SEND;
          end
        end
        SMF_TX_SEND: begin
          if (bit_end) begin
            shift_reg <= {1'b1, shift_reg[9:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == SMF_LAST_FRAME_BIT) begin
              tx_state_reg <= SMF_TX_IDLE;
            end
          end
        end
        SMF_TX_NACK: begin
          if (bit_end) begin
            tx_state_reg <= SMF_TX_IDLE;
          end
        end
      endcase
    end
  end

  // ****
  // line encoding
  // ****
  assign line_level = (tx_state_reg == SMF_TX_SEND) ? shift_reg[0] : (tx_state_reg != SMF_TX_NACK);
  // low-power pulse is one tick wide, normal is three sixteenths of a bit
  assign ir_pulse = ir_low_power ? (tick_cnt_reg == 4'h0) : (tick_cnt_reg < SMF_IR_PULSE_TICKS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pin_out <= 1'b1;
      ir_pin_out <= 1'b0;
    end else begin
      tx_pin_out <= ir_en ? 1'b1 : line_level;
      ir_pin_out <= ir_en & (tx_state_reg != SMF_TX_IDLE) & ~line_level & ir_pulse;
    end
  end

  // smartcard line is open drain; half duplex releases the wire when idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pin_oe <= 1'b1;
      rx_line_out <= 1'b1;
    end else begin
      if (sc_en) begin
        tx_pin_oe <= ~line_level;
      end else if (half_duplex) begin
        tx_pin_oe <= (tx_state_reg != SMF_TX_IDLE);
      end else begin
        tx_pin_oe <= 1'b1;
      end
      rx_line_out <= (half_duplex | sc_en) ? tx_pin_level_reg : rx_pin_level_reg;
    end
  end

endmodule

`default_nettype wire

// *** smf_pkg.sv ***
package smf_pkg;

  // ****
  // register map
  // ****
  localparam int unsigned SMF_ADDR_BITS = 12;
  localparam logic [11:0] SMF_CTRL_ONE_OFFSET = 12'h000;
  localparam logic [11:0] SMF_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] SMF_CTRL_THREE_OFFSET = 12'h008;
  localparam logic [11:0] SMF_DATA_OFFSET = 12'h00C;

  localparam logic [31:0] SMF_CTRL_ONE_RESET = 32'h0000_0000;
  localparam logic [31:0] SMF_CTRL_THREE_RESET = 32'h0000_0000;
  localparam logic [31:0] SMF_CTRL_THREE_MASK = 32'h0000_07FF;
  // enables that may only change while the port is off
  localparam logic [31:0] SMF_LOCKED_MASK = 32'h0000_033E;
  localparam logic [31:0] SMF_FREE_MASK = 32'h0000_04C1;

  // ****
  // field positions
  // ****
  localparam int unsigned SMF_PORT_ENABLE_BIT = 0;

  localparam int unsigned SMF_ERROR_IRQ_ENABLE_BIT = 0;
  localparam int unsigned SMF_INFRARED_MODE_ENABLE_BIT = 1;
  localparam int unsigned SMF_INFRARED_LOW_POWER_ENABLE_BIT = 2;
  localparam int unsigned SMF_HALF_DUPLEX_ENABLE_BIT = 3;
  localparam int unsigned SMF_SMARTCARD_NACK_ENABLE_BIT = 4;
  localparam int unsigned SMF_SMARTCARD_MODE_ENABLE_BIT = 5;
  localparam int unsigned SMF_RX_DMA_REQUEST_ENABLE_BIT = 6;
  localparam int unsigned SMF_TX_DMA_REQUEST_ENABLE_BIT = 7;
  localparam int unsigned SMF_REQUEST_TO_SEND_ENABLE_BIT = 8;
  localparam int unsigned SMF_CLEAR_TO_SEND_ENABLE_BIT = 9;
  localparam int unsigned SMF_CTS_CHANGE_IRQ_ENABLE_BIT = 10;

  localparam int unsigned SMF_FRAMING_ERROR_FLAG_BIT = 0;
  localparam int unsigned SMF_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int unsigned SMF_NOISE_ERROR_FLAG_BIT = 2;
  localparam int unsigned SMF_CTS_CHANGE_FLAG_BIT = 3;
  localparam int unsigned SMF_CTS_LEVEL_BIT = 4;
  localparam int unsigned SMF_TX_ROOM_BIT = 5;
  localparam int unsigned SMF_RX_FULL_BIT = 6;
  localparam int unsigned SMF_TX_BUSY_BIT = 7;

  // ****
  // line timing
  // ****
  localparam logic [3:0] SMF_LAST_TICK = 4'hF;
  localparam logic [3:0] SMF_LAST_FRAME_BIT = 4'h9;
  localparam logic [3:0] SMF_IR_PULSE_TICKS = 4'h3;

  typedef enum logic [2:0] {
    SMF_TX_IDLE = 3'b001,
    SMF_TX_SEND = 3'b010,
    SMF_TX_NACK = 3'b100
  } smf_tx_state_type;

endpackage

// *** smf_tx_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module smf_tx_buffer
  import smf_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("smf_tx_buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge hclk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** smf_mode_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module smf_mode_ctrl_sva
  import smf_pkg::*;
#(
  parameter int unsigned BAUD_DIV = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cts_n_pin,
  input wire logic rts_n_pin,
  input wire logic tx_pin_out,
  input wire logic framing_error_event,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req,
  input wire logic irq
);
  // ****
  // shadow of control three
  // ****
  // longer than any run of ones inside a frame
  localparam int QUIET = 160 * BAUD_DIV;
  logic w_q;
  logic port_on;
  logic [11:0] a_q;
  logic [31:0] c3;
  logic [15:0] quiet;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 12'h000;
    end else if (hready) begin
      w_q <= hsel && htrans[1] && hwrite && hsize == 3'h2;
      a_q <= haddr[11:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_on <= 1'b0;
      c3 <= SMF_CTRL_THREE_RESET;
    end else if (w_q && hreadyout && a_q == SMF_CTRL_ONE_OFFSET) begin
      port_on <= hwdata[SMF_PORT_ENABLE_BIT];
    end else if (w_q && hreadyout && a_q == SMF_CTRL_THREE_OFFSET) begin
      c3 <= port_on ? (c3 & SMF_LOCKED_MASK) | (hwdata & SMF_FREE_MASK) : hwdata & SMF_CTRL_THREE_MASK;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet <= 16'h0000;
    else if (!(tx_pin_out && cts_n_pin)) quiet <= 16'h0000;
    else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence read_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a:
    assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a:
    assert property (read_taken |=> one_wait) else $error("read wait state wrong");
  write_fast_a:
    assert property (hsel && hready && htrans[1] && hwrite && haddr[11:0] != SMF_DATA_OFFSET |=> hreadyout)
      else $error("register write stalled");
  rx_dma_gate_a:
    assert property (!c3[6] |-> !rx_dma_req) else $error("receive dma request while disabled");
  tx_dma_gate_a:
    assert property (!c3[7] |-> !tx_dma_req) else $error("transmit dma request while disabled");
  rts_off_a:
    assert property (!c3[8] && !$past(c3[8]) |-> !rts_n_pin) else $error("rts raised with flow control off");
  rts_room_a:
    assert property (c3[8] && c3[6] && $past(c3[8] && c3[6]) && $stable(rx_dma_req) |-> rts_n_pin == rx_dma_req)
      else $error("rts does not follow receive room");
  cts_hold_a:
    assert property (c3[9] && !c3[5] && quiet >= QUIET |=> tx_pin_out) else $error("start bit while cts high");
  irq_err_a:
    assert property (c3[0] && framing_error_event |-> ##[1:3] irq) else $error("error interrupt missing");
  irq_mask_a:
    assert property (!$past(c3[0]) && !$past(c3[10]) |-> !irq) else $error("interrupt while masked");
endmodule
bind smf_mode_ctrl smf_mode_ctrl_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (.*);
`default_nettype wire

// *** smf_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smf_peer_model #(
  parameter int BIT_CLOCKS = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic line_in,
  input wire logic rts_n_pin,
  input wire logic can_accept,
  input wire logic send_req,
  input wire logic [7:0] send_data,
  output logic cts_n_pin,
  output logic char_valid,
  output logic [7:0] char_data,
  output logic got_valid,
  output logic [7:0] got_data
);
  int cnt;
  int nb;
  int gap;
  logic busy;
  logic pend;
  logic [7:0] pdat;
  assign cts_n_pin = !can_accept;
  // a real peer needs a frame time between characters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      gap <= 0;
      char_valid <= 1'b0;
      char_data <= 8'h00;
      pdat <= 8'h00;
    end else begin
      char_valid <= 1'b0;
      char_data <= ~char_data;
      if (gap != 0) gap <= gap - 1;
      if (send_req) begin
        pend <= 1'b1;
        pdat <= send_data;
      end else if (pend && !rts_n_pin && gap == 0) begin
        pend <= 1'b0;
        char_valid <= 1'b1;
        char_data <= pdat;
        gap <= 10 * BIT_CLOCKS;
      end
    end
  end
  // ****
  // line decoder, samples mid bit
  // ****
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt <= 0;
      nb <= 0;
      got_valid <= 1'b0;
      got_data <= 8'h00;
    end else begin
      got_valid <= 1'b0;
      if (!busy) begin
        if (!line_in) begin
          busy <= 1'b1;
          cnt <= BIT_CLOCKS + BIT_CLOCKS / 2;
          nb <= 0;
        end
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (nb == 8) begin
        busy <= 1'b0;
        got_valid <= line_in;
      end else begin
        got_data <= {line_in, got_data[7:1]};
        nb <= nb + 1;
        cnt <= BIT_CLOCKS - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** serial_port_mode_flow_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_port_mode_flow_control_tb;
  import smf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, framing_error_event, accept, send_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] send_data, rx_char_data, got_data;
  logic hreadyout, hresp, cts_n_pin, rts_n_pin, tx_pin_out, tx_pin_oe, rx_char_valid;
  logic rx_dma_req, tx_dma_req, irq, got_valid, tx_wire;
  int error_cnt = 0;
  int total_checks = 0;
  // tx wire has a pull-up when nobody drives it
  assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;
  smf_mode_ctrl #(.BAUD_DIV(1), .TX_DEPTH(2)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cts_n_pin, .rts_n_pin, .rx_pin(1'b1),
    .tx_pin_in(tx_wire), .tx_pin_out, .tx_pin_oe, .ir_pin_out(), .rx_line_out(), .rx_char_valid, .rx_char_data,
    .rx_parity_error(1'b0), .framing_error_event, .noise_error_event(framing_error_event),
    .overrun_error_event(framing_error_event),
    .rx_dma_req, .tx_dma_req, .irq);
  smf_peer_model #(.BIT_CLOCKS(16)) peer (.hclk, .hresetn, .line_in(tx_wire), .rts_n_pin, .can_accept(accept),
    .send_req, .send_data, .cts_n_pin, .char_valid(rx_char_valid), .char_data(rx_char_data), .got_valid,
    .got_data);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ****
  // bus and check helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic setup(input logic [31:0] v);
    wr(SMF_CTRL_ONE_OFFSET, 32'h0000_0000);
    wr(SMF_CTRL_THREE_OFFSET, v);
    wr(SMF_CTRL_ONE_OFFSET, 32'h0000_0001);
  endtask
  task automatic send(input logic [7:0] d);
    send_req <= 1'b1;
    send_data <= d;
    @(posedge hclk);
    send_req <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic expect_char(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (got_valid !== 1'b1 && n < 400);
    chk({23'h00_0000, got_valid, got_data}, {23'h00_0000, 1'b1, exp});
  endtask
  task automatic no_char(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles) begin
      @(posedge hclk);
      seen |= got_valid === 1'b1;
    end
    chk1(seen, 1'b0);
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_regs();
    rd(SMF_CTRL_THREE_OFFSET, 32'h0000_0000);
    setup(32'h0000_07FF);
    rd(SMF_CTRL_THREE_OFFSET, 32'h0000_07FF);
    wr(SMF_CTRL_THREE_OFFSET, 32'h0000_0000);
    rd(SMF_CTRL_THREE_OFFSET, SMF_LOCKED_MASK);
    wr(SMF_CTRL_ONE_OFFSET, 32'h0000_0000);
    wr(SMF_CTRL_THREE_OFFSET, 32'hFFFF_F800);
    rd(SMF_CTRL_THREE_OFFSET, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    $display("register test done");
  endtask
  task automatic test_dma();
    setup(32'h0000_0080);
    @(negedge hclk);
    chk1(tx_dma_req, 1'b1);
    wr(SMF_CTRL_THREE_OFFSET, 32'h0000_0000);
    @(negedge hclk);
    chk1(tx_dma_req, 1'b0);
    $display("dma test done");
  endtask
  task automatic test_rts();
    setup(32'h0000_0140);
    send(8'h5A);
    send(8'hA5);
    repeat (20) @(posedge hclk);
    chk1(rts_n_pin, 1'b1);
    chk1(rx_dma_req, 1'b1);
    repeat (200) @(posedge hclk);
    rd(SMF_DATA_OFFSET, 32'h0000_005A);
    repeat (200) @(posedge hclk);
    rd(SMF_DATA_OFFSET, 32'h0000_00A5);
    repeat (4) @(posedge hclk);
    chk1(rts_n_pin, 1'b0);
    $display("rts test done");
  endtask
  task automatic test_cts();
    setup(32'h0000_0200);
    accept <= 1'b0;
    // filtered cts lags the pin by a few clocks
    repeat (8) @(posedge hclk);
    wr(SMF_DATA_OFFSET, 32'h0000_00A5);
    no_char(400);
    accept <= 1'b1;
    expect_char(8'hA5);
    wr(SMF_DATA_OFFSET, 32'h0000_003C);
    wr(SMF_DATA_OFFSET, 32'h0000_00C3);
    repeat (40) @(posedge hclk);
    accept <= 1'b0;
    expect_char(8'h3C);
    no_char(400);
    accept <= 1'b1;
    expect_char(8'hC3);
    $display("cts test done");
  endtask
  task automatic test_irq();
    setup(32'h0000_0601);
    // stale cts change flag from the cts test would mask the error check
    wr(SMF_STATUS_OFFSET, 32'h0000_000F);
    framing_error_event <= 1'b1;
    @(posedge hclk);
    framing_error_event <= 1'b0;
    repeat (3) @(posedge hclk);
    chk1(irq, 1'b1);
    wr(SMF_STATUS_OFFSET, 32'h0000_000F);
    repeat (3) @(posedge hclk);
    chk1(irq, 1'b0);
    accept <= 1'b0;
    repeat (8) @(posedge hclk);
    chk1(irq, 1'b1);
    wr(SMF_CTRL_THREE_OFFSET, 32'h0000_0200);
    wr(SMF_STATUS_OFFSET, 32'h0000_000F);
    accept <= 1'b1;
    framing_error_event <= 1'b1;
    @(posedge hclk);
    framing_error_event <= 1'b0;
    repeat (8) @(posedge hclk);
    chk1(irq, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    framing_error_event = 1'b0;
    accept = 1'b1;
    send_req = 1'b0;
    send_data = 8'h00;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_dma();
    test_rts();
    test_cts();
    test_irq();
    conclude();
  end
endmodule
`default_nettype wire
